// ### rtl/tlbw_pkg.sv
package tlbw_pkg;
  // translation buffer geometry
  localparam int SETS       = 64;
  localparam int WAYS       = 2;
  localparam int GROUP_LAST = 7;
  // cache mode bits for table reads (write-through, inhibit, coherent)
  localparam logic [2:0] WALK_CACHE_MODE = 3'h1;
  // register offsets, fields and reset values
  localparam logic [3:0]  REG_TABLE      = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam int          ORG_LSB        = 16;
  localparam int          MASK_MSB       = 8;
  localparam logic [15:0] TABLE_ORG_RST  = 16'h0000;
  localparam logic [8:0]  TABLE_MASK_RST = 9'h000;
  // page table entry fields inside one 64-bit beat
  localparam int E_VALID    = 63;
  localparam int E_SEG_MSB  = 62;
  localparam int E_SEG_LSB  = 39;
  localparam int E_HASH     = 38;
  localparam int E_PAGE_MSB = 37;
  localparam int E_PAGE_LSB = 32;
  localparam int E_RPN_MSB  = 31;
  localparam int E_RPN_LSB  = 12;
  localparam int E_REF      = 8;
  localparam int E_CHG      = 7;
  localparam int E_MODE_MSB = 6;
  localparam int E_MODE_LSB = 3;
  // effective address fields, little-endian numbering
  localparam int EFF_SET_MSB  = 17;
  localparam int EFF_SET_LSB  = 12;
  localparam int EFF_TAG_MSB  = 27;
  localparam int EFF_TAG_LSB  = 18;
  localparam int EFF_PI_LSB   = 12;
  localparam int EFF_ABBR_LSB = 22;
  localparam int EFF_BC_MSB   = 19;

  typedef enum logic [1:0] {
    BUS_READ    = 2'b00,
    BUS_WRITE   = 2'b01,
    BUS_INVAL   = 2'b10,
    BUS_TLBSYNC = 2'b11
  } tlbw_bus_t;

  typedef enum logic [2:0] {
    W_IDLE  = 3'b000,
    W_RDREQ = 3'b001,
    W_BEAT  = 3'b010,
    W_WRREQ = 3'b011,
    W_FILL  = 3'b100
  } tlbw_walk_t;
endpackage

// ### rtl/tlbw_walker.sv
`timescale 1ns/10ps
module tlbw_walker
  import tlbw_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // instruction events
  input  wire logic        tlbie_exec,
  input  wire logic [31:0] tlbie_eff,
  input  wire logic        tlbsync_exec,
  input  wire logic        tlbia_decode,
  input  wire logic        multi_string_busy,
  output logic             illegal_instr,
  output logic             inval_busy,
  // mmu register access
  input  wire logic        mmu_reg_read,
  input  wire logic        mmu_reg_update,
  input  wire logic        mmu_reg_complete,
  output logic             instr_mmu_stall,
  output logic             fetch_flush,
  output logic             fetch_stall,
  output logic             exec_serialize,
  // translation request
  input  wire logic        trans_req,
  input  wire logic        trans_side,
  input  wire logic [23:0] trans_seg,
  input  wire logic [31:0] trans_eff,
  input  wire logic        trans_write,
  input  wire logic        trans_spec,
  input  wire logic        trans_dcbz,
  output logic             trans_done,
  output logic             trans_hit,
  output logic      [19:0] trans_rpn,
  output logic             trans_miss,
  output logic             trans_busy,
  output logic             trans_deferred,
  output logic             trans_align,
  output logic             walk_retry,
  output logic             instr_storage_fault,
  output logic             data_storage_fault,
  // system bus master
  output logic             bus_req,
  output tlbw_bus_t        bus_type,
  output logic      [31:0] bus_addr,
  output logic      [31:0] bus_wdata,
  output logic      [2:0]  bus_cache_mode_bits,
  output logic             bus_global,
  output logic             bus_burst,
  input  wire logic        bus_gnt,
  input  wire logic        bus_rvalid,
  input  wire logic [63:0] bus_rdata,
  // snoop
  input  wire logic        snoop_valid,
  input  wire tlbw_bus_t   snoop_type,
  input  wire logic [31:0] snoop_addr,
  input  wire logic        snoop_retry_in,
  output logic             address_retry
);

  logic        tv    [2][SETS][WAYS];
  logic [23:0] tseg  [2][SETS][WAYS];
  logic [9:0]  ttag  [2][SETS][WAYS];
  logic [19:0] trpn  [2][SETS][WAYS];
  logic [3:0]  tmode [2][SETS][WAYS];
  logic        repl  [2][SETS];

  logic [15:0] table_org;
  logic [8:0]  table_mask;
  tlbw_walk_t  wstate;
  logic        w_side;
  logic [23:0] w_seg;
  logic [31:0] w_eff;
  logic        w_write;
  logic        w_secondary;
  logic        w_found;
  logic [2:0]  w_beat;
  logic [2:0]  w_hit_idx;
  logic [63:0] w_entry;
  logic        bcast_pend;
  logic [31:0] bcast_addr;
  logic        sync_pend;
  logic        cand;
  logic [5:0]  cand_idx;
  logic        inval_pend;
  logic [5:0]  inval_idx;
  logic        stale_dep;

  logic [1:0]  hit_way;
  logic        lk_hit;
  logic        lk_way;
  logic        lk_take;
  logic        walk_start;
  logic        inval_do;
  logic [5:0]  lk_set;
  logic [5:0]  w_set;
  logic        fill_way;
  logic [18:0] hash;
  logic [18:0] hsel;
  logic [31:0] group_addr;
  logic        beat_match;
  logic [63:0] sel_entry;
  logic [63:0] upd_entry;
  logic        viol;
  logic        rd_granted;

  assign lk_set = trans_eff[EFF_SET_MSB:EFF_SET_LSB];
  assign w_set  = w_eff[EFF_SET_MSB:EFF_SET_LSB];

  // lookup: both ways of the indexed set compared at once
  always_comb begin
    for (int w = 0; w < WAYS; w++) begin
      hit_way[w] = tv[trans_side][lk_set][w] && tseg[trans_side][lk_set][w] == trans_seg
                   && ttag[trans_side][lk_set][w] == trans_eff[EFF_TAG_MSB:EFF_TAG_LSB];
    end
  end
  assign lk_hit  = |hit_way;
  assign lk_way  = hit_way[1];
  assign lk_take = trans_req && !(trans_side == 1'b0 && instr_mmu_stall);
  assign walk_start = lk_take && !lk_hit && !trans_spec && wstate == W_IDLE;
  assign inval_do = inval_pend && !multi_string_busy;
  assign fill_way = !tv[w_side][w_set][0] ? 1'b0 :
                    !tv[w_side][w_set][1] ? 1'b1 : repl[w_side][w_set];

  // group address and entry match
  assign hash = w_seg[18:0] ^ {3'h0, w_eff[EFF_TAG_MSB:EFF_PI_LSB]};
  assign hsel = w_secondary ? ~hash : hash;
  assign group_addr = {table_org[15:9], table_org[8:0] | (hsel[18:10] & table_mask),
                       hsel[9:0], 6'h00};
  assign beat_match = bus_rdata[E_VALID] && bus_rdata[E_HASH] == w_secondary
                      && bus_rdata[E_SEG_MSB:E_SEG_LSB] == w_seg
                      && bus_rdata[E_PAGE_MSB:E_PAGE_LSB] == w_eff[EFF_TAG_MSB:EFF_ABBR_LSB];
  assign sel_entry = w_found ? w_entry : bus_rdata;
  assign viol = w_write && sel_entry[1:0] == 2'b11;
  always_comb begin
    upd_entry = sel_entry;
    upd_entry[E_REF] = 1'b1;
    if (w_write && !viol) begin
      upd_entry[E_CHG] = 1'b1;
    end
  end
  assign rd_granted = bus_req && bus_gnt && bus_type == BUS_READ;

  // translation arrays; valid cleared at reset for a known start
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int s = 0; s < 2; s++) begin
        for (int i = 0; i < SETS; i++) begin
          repl[s][i] <= 1'b0;
          for (int w = 0; w < WAYS; w++) begin
            tv[s][i][w] <= 1'b0;
          end
        end
      end
    end else begin
      if (lk_take && lk_hit) begin
        repl[trans_side][lk_set] <= !lk_way;
      end
      if (wstate == W_FILL) begin
        tv[w_side][w_set][fill_way]    <= 1'b1;
        tseg[w_side][w_set][fill_way]  <= w_seg;
        ttag[w_side][w_set][fill_way]  <= w_eff[EFF_TAG_MSB:EFF_TAG_LSB];
        trpn[w_side][w_set][fill_way]  <= w_entry[E_RPN_MSB:E_RPN_LSB];
        tmode[w_side][w_set][fill_way] <= w_entry[E_MODE_MSB:E_MODE_LSB];
        repl[w_side][w_set]            <= !fill_way;
      end
      for (int s = 0; s < 2; s++) begin
        for (int w = 0; w < WAYS; w++) begin
          if (tlbie_exec) begin
            tv[s][tlbie_eff[EFF_SET_MSB:EFF_SET_LSB]][w] <= 1'b0;
          end
          if (inval_do) begin
            tv[s][inval_idx][w] <= 1'b0;
          end
        end
      end
    end
  end

  // lookup answers, one cycle after the request
  always_ff @(posedge clk) begin
    if (reset) begin
      trans_done     <= 1'b0;
      trans_hit      <= 1'b0;
      trans_rpn      <= 20'h0_0000;
      trans_miss     <= 1'b0;
      trans_busy     <= 1'b0;
      trans_deferred <= 1'b0;
      trans_align    <= 1'b0;
    end else begin
      trans_done     <= trans_req;
      trans_hit      <= lk_take && lk_hit;
      trans_miss     <= walk_start;
      trans_busy     <= trans_req && (!lk_take || (!lk_hit && !trans_spec && !walk_start));
      trans_deferred <= lk_take && !lk_hit && trans_spec;
      trans_align    <= lk_take && lk_hit && trans_dcbz
                        && (tmode[trans_side][lk_set][lk_way][3]
                        || tmode[trans_side][lk_set][lk_way][2]);
      if (lk_take && lk_hit) begin
        trans_rpn <= trpn[trans_side][lk_set][lk_way];
      end
    end
  end

  // table search
  always_ff @(posedge clk) begin
    if (reset) begin
      wstate              <= W_IDLE;
      w_side              <= 1'b0;
      w_seg               <= 24'h00_0000;
      w_eff               <= 32'h0000_0000;
      w_write             <= 1'b0;
      w_secondary         <= 1'b0;
      w_found             <= 1'b0;
      w_beat              <= 3'h0;
      w_hit_idx           <= 3'h0;
      w_entry             <= 64'h0000_0000_0000_0000;
      walk_retry          <= 1'b0;
      instr_storage_fault <= 1'b0;
      data_storage_fault  <= 1'b0;
    end else begin
      walk_retry          <= 1'b0;
      instr_storage_fault <= 1'b0;
      data_storage_fault  <= 1'b0;
      unique case (wstate)
        W_IDLE: begin
          if (walk_start) begin
            w_side      <= trans_side;
            w_seg       <= trans_seg;
            w_eff       <= trans_eff;
            w_write     <= trans_write;
            w_secondary <= 1'b0;
            w_found     <= 1'b0;
            wstate      <= W_RDREQ;
          end
        end
        W_RDREQ: begin
          if (rd_granted) begin
            w_beat <= 3'h0;
            wstate <= W_BEAT;
          end
        end
        W_BEAT: begin
          if (bus_rvalid) begin
            w_beat <= w_beat + 3'h1;
            if (beat_match && !w_found) begin
              w_found   <= 1'b1;
              w_entry   <= bus_rdata;
              w_hit_idx <= w_beat;
            end
            if (w_beat == 3'(GROUP_LAST)) begin
              if (w_found || beat_match) begin
                w_found <= 1'b1;
                w_entry <= upd_entry;
                wstate  <= (upd_entry != sel_entry) ? W_WRREQ : W_FILL;
              end else if (!w_secondary) begin
                w_secondary <= 1'b1;
                wstate      <= W_RDREQ;
              end else begin
                instr_storage_fault <= !w_side;
                data_storage_fault  <= w_side;
                wstate              <= W_IDLE;
              end
            end
          end
        end
        W_WRREQ: begin
          if (bus_req && bus_gnt && bus_type == BUS_WRITE) begin
            wstate <= W_FILL;
          end
        end
        W_FILL: begin
          walk_retry <= 1'b1;
          w_found    <= 1'b0;
          wstate     <= W_IDLE;
        end
        default: wstate <= W_IDLE;
      endcase
    end
  end

  // bus master: broadcasts first, then table traffic
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_req             <= 1'b0;
      bus_type            <= BUS_READ;
      bus_addr            <= 32'h0000_0000;
      bus_wdata           <= 32'h0000_0000;
      bus_cache_mode_bits <= 3'h0;
      bus_global          <= 1'b0;
      bus_burst           <= 1'b0;
      bcast_pend          <= 1'b0;
      bcast_addr          <= 32'h0000_0000;
      sync_pend           <= 1'b0;
    end else begin
      if (bus_req && bus_gnt) begin
        bus_req <= 1'b0;
        if (bus_type == BUS_INVAL) begin
          bcast_pend <= 1'b0;
        end
        if (bus_type == BUS_TLBSYNC) begin
          sync_pend <= 1'b0;
        end
      end else if (!bus_req) begin
        bus_global          <= 1'b1;
        bus_burst           <= 1'b0;
        bus_cache_mode_bits <= 3'h0;
        if (bcast_pend) begin
          bus_req  <= 1'b1;
          bus_type <= BUS_INVAL;
          bus_addr <= bcast_addr;
        end else if (sync_pend) begin
          bus_req  <= 1'b1;
          bus_type <= BUS_TLBSYNC;
          bus_addr <= 32'h0000_0000;
        end else if (wstate == W_RDREQ) begin
          bus_req             <= 1'b1;
          bus_type            <= BUS_READ;
          bus_addr            <= group_addr;
          bus_burst           <= 1'b1;
          bus_cache_mode_bits <= WALK_CACHE_MODE;
        end else if (wstate == W_WRREQ) begin
          bus_req   <= 1'b1;
          bus_type  <= BUS_WRITE;
          bus_addr  <= group_addr | {26'h000_0000, w_hit_idx, 3'h4};
          bus_wdata <= w_entry[31:0];
        end
      end
      if (tlbie_exec) begin
        bcast_pend <= 1'b1;
        bcast_addr <= {12'h000, tlbie_eff[EFF_BC_MSB:EFF_SET_LSB], 12'h000};
      end
      if (tlbsync_exec) begin
        sync_pend <= 1'b1;
      end
    end
  end

  // snoop: decide retry, then accept if nobody retried
  always_ff @(posedge clk) begin
    if (reset) begin
      address_retry <= 1'b0;
      cand          <= 1'b0;
      cand_idx      <= 6'h00;
      inval_pend    <= 1'b0;
      inval_idx     <= 6'h00;
      stale_dep     <= 1'b0;
    end else begin
      address_retry <= 1'b0;
      cand          <= 1'b0;
      if (snoop_valid && snoop_type == BUS_INVAL) begin
        if (inval_pend || cand || bcast_pend) begin
          address_retry <= 1'b1;
        end else begin
          cand     <= 1'b1;
          cand_idx <= snoop_addr[EFF_SET_MSB:EFF_SET_LSB];
        end
      end
      if (snoop_valid && snoop_type == BUS_TLBSYNC) begin
        address_retry <= stale_dep || inval_pend || cand;
      end
      if (inval_do) begin
        inval_pend <= 1'b0;
      end
      if (cand && !snoop_retry_in) begin
        inval_pend <= 1'b1;
        inval_idx  <= cand_idx;
      end
      if (wstate == W_IDLE) begin
        stale_dep <= 1'b0;
      end
      if ((inval_do || tlbie_exec) && wstate != W_IDLE) begin
        stale_dep <= 1'b1;
      end
    end
  end

  // instruction side effects; invalidation leaves prefetch alone
  always_ff @(posedge clk) begin
    if (reset) begin
      illegal_instr   <= 1'b0;
      inval_busy      <= 1'b0;
      instr_mmu_stall <= 1'b0;
      fetch_flush     <= 1'b0;
      fetch_stall     <= 1'b0;
      exec_serialize  <= 1'b0;
    end else begin
      illegal_instr   <= tlbia_decode;
      inval_busy      <= bcast_pend || tlbie_exec || inval_pend;
      instr_mmu_stall <= mmu_reg_read || mmu_reg_update;
      fetch_flush     <= mmu_reg_update;
      exec_serialize  <= mmu_reg_read;
      if (mmu_reg_update) begin
        fetch_stall <= 1'b1;
      end else if (mmu_reg_complete) begin
        fetch_stall <= 1'b0;
      end
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      table_org  <= TABLE_ORG_RST;
      table_mask <= TABLE_MASK_RST;
      reg_rdata  <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_wr && reg_addr == REG_TABLE) begin
        table_org  <= reg_wdata[31:ORG_LSB];
        table_mask <= reg_wdata[MASK_MSB:0];
      end
      if (reg_rd && reg_addr == REG_TABLE) begin
        reg_rdata <= {table_org, 7'h00, table_mask};
      end
      if (reg_rd && reg_addr == REG_STATUS) begin
        reg_rdata <= {27'h000_0000, stale_dep, sync_pend, inval_pend, bcast_pend,
                      wstate != W_IDLE};
      end
    end
  end

  sequence s_primary_empty;
    wstate == W_BEAT && bus_rvalid && w_beat == 3'h7 && !w_secondary && !w_found && !beat_match;
  endsequence

  a_retry_pending: assert property (@(posedge clk) disable iff (reset)
    snoop_valid && snoop_type == BUS_INVAL && inval_pend |=> address_retry)
    else $error("pending invalidate not retried");
  a_string_wait: assert property (@(posedge clk) disable iff (reset)
    inval_pend && multi_string_busy && !(cand && !snoop_retry_in) |=> inval_pend)
    else $error("invalidate ran during string instruction");
  a_snoop_clears: assert property (@(posedge clk) disable iff (reset)
    inval_do && wstate != W_FILL |=> !tv[0][$past(inval_idx)][0] && !tv[0][$past(inval_idx)][1]
    && !tv[1][$past(inval_idx)][0] && !tv[1][$past(inval_idx)][1])
    else $error("snooped class not cleared");
  a_bcast_addr: assert property (@(posedge clk) disable iff (reset)
    bus_req && bus_type == BUS_INVAL |-> bus_addr[11:0] == 12'h000 && bus_addr[31:20] == 12'h000)
    else $error("broadcast address out of range");
  a_read_mode: assert property (@(posedge clk) disable iff (reset)
    bus_req && bus_type == BUS_READ |-> bus_cache_mode_bits == 3'h1 && bus_burst && bus_global)
    else $error("table read attributes wrong");
  a_secondary_next: assert property (@(posedge clk) disable iff (reset)
    s_primary_empty |=> wstate == W_RDREQ && w_secondary ##[1:40] bus_req && bus_type == BUS_READ)
    else $error("secondary group not searched");
  a_spec_nowalk: assert property (@(posedge clk) disable iff (reset)
    trans_req && trans_spec && wstate == W_IDLE |=> wstate == W_IDLE)
    else $error("speculative miss started a walk");
  a_sync_retry: assert property (@(posedge clk) disable iff (reset)
    snoop_valid && snoop_type == BUS_TLBSYNC && stale_dep |=> address_retry)
    else $error("synchronize not retried");
  a_illegal_all: assert property (@(posedge clk) disable iff (reset)
    tlbia_decode |=> illegal_instr)
    else $error("invalidate-all not illegal");
  a_fault_side: assert property (@(posedge clk) disable iff (reset)
    wstate == W_BEAT && bus_rvalid && w_beat == 3'h7 && w_secondary && !w_found && !beat_match
    |=> (instr_storage_fault ^ data_storage_fault) && wstate == W_IDLE)
    else $error("failed walk not reported");
endmodule

// ### verification/tlbw_bus_model.sv
`timescale 1ns/10ps
module tlbw_bus_model
  import tlbw_pkg::*;
(
  // walker bus
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        bus_req,
  input  wire tlbw_bus_t   bus_type,
  input  wire logic [31:0] bus_wdata,
  output logic             bus_gnt,
  output logic             bus_rvalid,
  output logic      [63:0] bus_rdata,
  // table contents
  input  wire logic        slow,
  input  wire logic        walk_clr,
  input  wire logic [63:0] entry,
  input  wire logic [3:0]  sec_beat,
  output logic      [31:0] last_wdata,
  output logic      [3:0]  n_reads
);
  logic [1:0]  wait_n;
  logic [3:0]  left;
  logic [2:0]  beat;
  logic        tick;
  logic [63:0] hash_bit;
  assign hash_bit = 64'h1 << E_HASH;
  always_ff @(posedge clk) begin
    if (reset) begin
      {bus_gnt, bus_rvalid, wait_n, left, beat, tick, n_reads} <= '0;
      bus_rdata  <= '0;
      last_wdata <= '0;
    end else begin
      bus_gnt    <= 1'b0;
      bus_rvalid <= 1'b0;
      // released data lines toggle
      bus_rdata  <= ~bus_rdata;
      tick       <= ~tick;
      if (walk_clr) n_reads <= '0;
      if (bus_req && !bus_gnt) wait_n <= wait_n + 2'h1;
      if (bus_req && !bus_gnt && wait_n == 2'h2) begin
        bus_gnt <= 1'b1;
        wait_n  <= '0;
        if (bus_type == BUS_READ) begin
          left    <= 4'h8;
          beat    <= '0;
          n_reads <= n_reads + 4'h1;
        end
        if (bus_type == BUS_WRITE) last_wdata <= bus_wdata;
      end
      if (left != 4'h0 && (!slow || tick)) begin
        bus_rvalid <= 1'b1;
        left       <= left - 4'h1;
        beat       <= beat + 3'h1;
        // primary group carries the wrong hash everywhere
        bus_rdata  <= (n_reads < 4'h2 || {1'b0, beat} == sec_beat) ?
                      entry | hash_bit : entry & ~hash_bit;
      end
    end
  end
endmodule

// ### verification/tlbw_walker_tb.sv
`timescale 1ns/10ps
module tlbw_walker_tb
  import tlbw_pkg::*;
;
  typedef struct packed {
    logic [2:0] ev;
    logic [3:0] exp;
  } tlbw_row_t;
  localparam logic [31:0] EFF   = 32'h0a83_5000;
  localparam logic [31:0] EFF2  = 32'h0a80_2000;
  localparam logic [23:0] SEG   = 24'h5a_c3e1;
  localparam logic [63:0] ENTRY = {1'b1, SEG, 1'b0, EFF[27:22], 20'h3_c0de, 5'h00, 4'h4, 3'h0};
  tlbw_row_t   rows [3] = '{'{3'h4, 4'h8}, '{3'h2, 4'h5}, '{3'h1, 4'h6}};
  int          n_errors    = 0;
  int          comparisons = 0;
  logic        clk   = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr, sec_beat, n_reads;
  logic [31:0] reg_wdata, reg_rdata, tlbie_eff, trans_eff, bus_addr, bus_wdata, last_wdata;
  logic [31:0] snoop_addr;
  logic [23:0] trans_seg;
  logic [19:0] trans_rpn;
  logic [63:0] bus_rdata;
  logic [4:0]  rd_attr;
  logic [2:0]  bus_cache_mode_bits;
  tlbw_bus_t   bus_type, snoop_type;
  logic        reg_wr, reg_rd, tlbie_exec, tlbsync_exec, tlbia_decode, multi_string_busy;
  logic        illegal_instr, mmu_reg_read, mmu_reg_update, mmu_reg_complete, instr_mmu_stall;
  logic        fetch_flush, fetch_stall, exec_serialize, trans_req, trans_side, trans_write;
  logic        trans_spec, trans_dcbz, trans_done, trans_hit, trans_miss, trans_busy;
  logic        trans_deferred, trans_align, walk_retry, instr_storage_fault, bus_req;
  logic        bus_global, bus_burst, bus_gnt, bus_rvalid, snoop_valid, snoop_retry_in;
  logic        address_retry, slow, walk_clr, inval_busy, data_storage_fault;
  always #2 clk = ~clk;
  tlbw_walker uut (
    .clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tlbie_exec,
    .tlbie_eff, .tlbsync_exec, .tlbia_decode, .multi_string_busy, .illegal_instr,
    .inval_busy, .mmu_reg_read, .mmu_reg_update, .mmu_reg_complete, .instr_mmu_stall,
    .fetch_flush, .fetch_stall, .exec_serialize, .trans_req, .trans_side, .trans_seg,
    .trans_eff, .trans_write, .trans_spec, .trans_dcbz, .trans_done, .trans_hit, .trans_rpn,
    .trans_miss, .trans_busy, .trans_deferred, .trans_align, .walk_retry, .instr_storage_fault,
    .data_storage_fault, .bus_req, .bus_type, .bus_addr, .bus_wdata, .bus_cache_mode_bits,
    .bus_global, .bus_burst, .bus_gnt, .bus_rvalid, .bus_rdata, .snoop_valid, .snoop_type,
    .snoop_addr, .snoop_retry_in, .address_retry
  );
  tlbw_bus_model bus (
    .clk, .reset, .bus_req, .bus_type, .bus_wdata, .bus_gnt, .bus_rvalid, .bus_rdata, .slow,
    .walk_clr, .entry(ENTRY), .sec_beat, .last_wdata, .n_reads
  );
  always @(posedge clk)
    if (bus_req && bus_type == BUS_READ) rd_attr <= {bus_cache_mode_bits, bus_global, bus_burst};
  task automatic check(input string name, input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic lookup(input logic side, wr, spec, dcbz);
    @(posedge clk);
    {trans_req, trans_side, trans_write, trans_spec, trans_dcbz} <= {1'b1, side, wr, spec, dcbz};
    @(posedge clk);
    trans_req <= 1'b0;
    #1;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", reg_rdata, exp);
  endtask
  task automatic bus_op(input tlbw_bus_t t);
    int n;
    for (n = 0; n < 40 && !(bus_req && bus_type == t); n++) begin
      @(posedge clk);
      #1;
    end
    check("bus op", {bus_req, bus_type}, {1'b1, t});
  endtask
  task automatic snoop(input tlbw_bus_t t, input logic exp);
    @(posedge clk);
    snoop_valid <= 1'b1;
    snoop_type  <= t;
    @(posedge clk);
    snoop_valid <= 1'b0;
    #1 check("address_retry", address_retry, exp);
  endtask
  task automatic walk(input logic side, input logic [31:0] eff, input logic [3:0] sel,
                      input logic ok);
    int n;
    @(posedge clk);
    walk_clr  <= 1'b1;
    sec_beat  <= sel;
    trans_eff <= eff;
    @(posedge clk);
    walk_clr <= 1'b0;
    lookup(side, side, 1'b0, 1'b0);
    check("trans_miss", trans_miss, 1'b1);
    lookup(side, side, 1'b0, 1'b0);
    check("trans_busy", trans_busy, 1'b1);
    for (n = 0; n < 400 && !(walk_retry || instr_storage_fault || data_storage_fault); n++) begin
      @(posedge clk);
      #1;
    end
    check("walk end", {walk_retry, instr_storage_fault, data_storage_fault},
          {ok, !ok && !side, !ok && side});
    check("table reads", n_reads, 4'h2);
    check("read attrs", rd_attr, {WALK_CACHE_MODE, 2'h3});
    $display("test walk done");
  endtask
  initial begin
    {reg_addr, sec_beat, reg_wdata, tlbie_eff, trans_eff} = '0;
    {reg_wr, reg_rd, tlbie_exec, tlbsync_exec, tlbia_decode, multi_string_busy} = '0;
    {mmu_reg_read, mmu_reg_update, mmu_reg_complete, trans_req, trans_side} = '0;
    {trans_write, trans_spec, trans_dcbz, snoop_valid, walk_clr} = '0;
    snoop_retry_in = 1'b0;
    snoop_type     = BUS_READ;
    trans_seg      = SEG;
    snoop_addr     = EFF & 32'h000f_f000;
    slow           = 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    lookup(1'b1, 1'b0, 1'b1, 1'b0);
    check("empty lookup", {trans_hit, trans_deferred}, 2'h1);
    foreach (rows[i]) begin
      @(posedge clk);
      {tlbia_decode, mmu_reg_read, mmu_reg_update} <= rows[i].ev;
      @(posedge clk);
      {tlbia_decode, mmu_reg_read, mmu_reg_update} <= 3'h0;
      #1 check("events", {illegal_instr, instr_mmu_stall, fetch_flush, exec_serialize}, rows[i].exp);
    end
    check("fetch_stall", fetch_stall, 1'b1);
    @(posedge clk);
    mmu_reg_complete <= 1'b1;
    @(posedge clk);
    mmu_reg_complete <= 1'b0;
    @(posedge clk);
    #1 check("fetch_stall", fetch_stall, 1'b0);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= REG_TABLE;
    reg_wdata <= 32'h1234_01ff;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_read(REG_TABLE, 32'h1234_01ff);
    reg_read(4'h8, 32'h0);
    $display("test events and registers done");
    walk(1'b1, EFF, 4'h3, 1'b1);
    check("rc write", {last_wdata[E_REF], last_wdata[E_CHG]}, 2'h3);
    lookup(1'b1, 1'b0, 1'b0, 1'b0);
    check("refill hit", {trans_hit, trans_rpn}, {1'b1, ENTRY[E_RPN_MSB:E_RPN_LSB]});
    lookup(1'b1, 1'b0, 1'b0, 1'b1);
    check("dcbz", {trans_hit, trans_align}, 2'h3);
    // walk finished before the invalidate
    @(posedge clk);
    tlbie_exec <= 1'b1;
    tlbie_eff  <= EFF;
    @(posedge clk);
    tlbie_exec <= 1'b0;
    #1 check("inval_busy", inval_busy, 1'b1);
    bus_op(BUS_INVAL);
    check("inval addr", bus_addr & 32'h000f_f000, snoop_addr);
    lookup(1'b1, 1'b0, 1'b1, 1'b0);
    check("after local inval", {trans_hit, trans_deferred}, 2'h1);
    @(posedge clk);
    tlbsync_exec <= 1'b1;
    @(posedge clk);
    tlbsync_exec <= 1'b0;
    #1 bus_op(BUS_TLBSYNC);
    $display("test local invalidate done");
    walk(1'b1, EFF, 4'h7, 1'b1);
    @(posedge clk);
    multi_string_busy <= 1'b1;
    snoop(BUS_INVAL, 1'b0);
    snoop(BUS_INVAL, 1'b1);
    snoop(BUS_TLBSYNC, 1'b1);
    lookup(1'b1, 1'b0, 1'b1, 1'b0);
    check("delayed inval", trans_hit, 1'b1);
    reg_read(REG_STATUS, 32'h0000_0004);
    @(posedge clk);
    multi_string_busy <= 1'b0;
    repeat (3) @(posedge clk);
    lookup(1'b1, 1'b0, 1'b1, 1'b0);
    check("snoop inval", {trans_hit, trans_deferred}, 2'h1);
    // another participant retries: the candidate must not become pending
    @(posedge clk);
    snoop_retry_in <= 1'b1;
    snoop(BUS_INVAL, 1'b0);
    snoop(BUS_INVAL, 1'b0);
    @(posedge clk);
    snoop_retry_in <= 1'b0;
    $display("test snoop done");
    walk(1'b0, EFF2, 4'h8, 1'b0);
    walk(1'b1, EFF2, 4'h8, 1'b0);
    final_report();
  end
  // sequence needs a few hundred cycles
  initial begin
    #20000;
    n_errors++;
    final_report();
  end
endmodule
